//--- rtl/flash_cfg_pkg.sv
package flash_cfg_pkg;

  // Command codes
  localparam logic [7:0] CMD_WRITE_REGS       = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS_ONE  = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS_TWO  = 8'h07;
  localparam logic [7:0] CMD_BOOT_REG_READ    = 8'h14;
  localparam logic [7:0] CMD_BOOT_REG_WRITE   = 8'h15;
  localparam logic [7:0] CMD_READ_CONFIG_ONE  = 8'h35;
  localparam logic [7:0] CMD_SOFT_RESET       = 8'hF0;

  // config_one field positions
  localparam int CFG_LC_HI       = 7;
  localparam int CFG_LC_LO       = 6;
  localparam int CFG_PROT_BOTTOM = 5;
  localparam int CFG_BP_VOLATILE = 3;
  localparam int CFG_PARAM_TOP   = 2;
  localparam int CFG_QUAD        = 1;
  localparam int CFG_LOCK        = 0;

  // One-time settable bits, and those the lock freezes
  localparam logic [7:0] CFG_OTP_MASK    = 8'h2C;
  localparam logic [7:0] CFG_FROZEN_MASK = 8'h24;

  // status_reg_one field positions
  localparam int STS_PROG_ERR = 6;
  localparam int STS_BP_HI    = 4;
  localparam int STS_BP_LO    = 2;
  localparam int STS_WEL      = 1;

  // suspend_status field positions
  localparam int SUSP_ERASE = 1;
  localparam int SUSP_PROG  = 0;

  // boot_read_config field positions
  localparam int BOOT_ADDR_HI = 31;
  localparam int BOOT_ADDR_LO = 9;
  localparam int BOOT_DLY_HI  = 8;
  localparam int BOOT_DLY_LO  = 1;
  localparam int BOOT_EN      = 0;

  // Reset and load values
  localparam logic [7:0]  CONFIG_ONE_RST   = 8'h00;
  localparam logic [31:0] BOOT_REG_RST     = 32'h0000_0000;
  localparam logic [2:0]  BP_LEVEL_RST     = 3'h0;
  localparam logic [2:0]  BP_VOLATILE_LOAD = 3'h7;
  // Pin sync reset: {reset, hold, wp, si, cs, sck}
  localparam logic [5:0]  PIN_SYNC_RST     = 6'h3A;

  // DDR mode cycles per read kind
  localparam logic [2:0] MODE_DDR_FAST = 3'h4;
  localparam logic [2:0] MODE_DDR_DUAL = 3'h2;
  localparam logic [2:0] MODE_DDR_QUAD = 3'h1;
  // DDR dummy cycles, one nibble per latency code (nibble n = code n)
  localparam logic [15:0] DUMMY_DDR_FAST = 16'h1542;
  localparam logic [15:0] DUMMY_DDR_DUAL = 16'h2654;
  localparam logic [15:0] DUMMY_DDR_QUAD = 16'h3876;

  typedef enum logic [1:0] {
    DDR_FAST_READ,
    DDR_DUAL_READ,
    DDR_QUAD_READ
  } ddr_read_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_WRITE,
    ST_READ,
    ST_SKIP,
    ST_BOOT
  } link_state_t;

endpackage : flash_cfg_pkg

//--- rtl/latency_if.sv
`timescale 1ns/1ns
interface latency_if;
  import flash_cfg_pkg::*;
  ddr_read_kind_t kind;
  logic [1:0]     code;
  logic [2:0]     mode;
  logic [3:0]     dummy;
  modport client (output kind, output code, input mode, input dummy);
  modport lookup (input kind, input code, output mode, output dummy);
endinterface : latency_if

//--- rtl/ddr_latency_table.sv
`timescale 1ns/1ns
module ddr_latency_table
  import flash_cfg_pkg::*;
(
  // Lookup port
  latency_if.lookup lat
);

  logic [15:0] dummy_row;

  // Mode and dummy cycles per read kind and latency code
  always_comb begin
    case (lat.kind)
      DDR_FAST_READ: begin
        lat.mode  = MODE_DDR_FAST;
        dummy_row = DUMMY_DDR_FAST;
      end
      DDR_DUAL_READ: begin
        lat.mode  = MODE_DDR_DUAL;
        dummy_row = DUMMY_DDR_DUAL;
      end
      DDR_QUAD_READ: begin
        lat.mode  = MODE_DDR_QUAD;
        dummy_row = DUMMY_DDR_QUAD;
      end
      default: begin
        lat.mode  = 3'h0;
        dummy_row = 16'h0000;
      end
    endcase
    lat.dummy = dummy_row[{lat.code, 2'b00} +: 4];
  end

endmodule : ddr_latency_table

//--- rtl/flash_config_status_regs.sv
`timescale 1ns/1ns
module flash_config_status_regs
  import flash_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst_b,
  // Serial link pins
  input  wire logic           i_sck,
  input  wire logic           i_cs_b,
  input  wire logic           i_si,
  input  wire logic           i_wp_b,
  input  wire logic           i_hold_b,
  input  wire logic           i_reset_b,
  output logic                o_so,
  output logic                o_so_oe_b,
  // Array engine side
  input  wire logic           i_erase_suspended,
  input  wire logic           i_program_suspended,
  input  wire logic           i_uniform_sectors,
  input  wire ddr_read_kind_t i_ddr_read_kind,
  input  wire logic [7:0]     i_array_byte,
  output logic [31:0]         o_array_addr,
  output logic                o_boot_active,
  // Configuration towards the array
  output logic [1:0]          o_latency_code,
  output logic [2:0]          o_ddr_mode_cycles,
  output logic [3:0]          o_ddr_dummy_cycles,
  output logic [2:0]          o_block_prot_level,
  output logic                o_protect_from_bottom,
  output logic                o_param_sector_top,
  output logic                o_protection_locked,
  output logic                o_program_error,
  output logic                o_quad_en,
  output logic                o_wp_b_int,
  output logic                o_hold_b_int,
  output logic                o_data_line_two,
  output logic                o_data_line_three
);

  logic [5:0]  pin_meta;
  logic [5:0]  pin_sync;
  logic        sck_d;
  logic        cs_d;
  logic        sck_s;
  logic        cs_s;
  logic        si_s;
  logic        wp_s;
  logic        hold_s;
  logic        hw_low;
  logic        link_run;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        cs_fall;
  link_state_t st;
  link_state_t next_st;
  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [7:0]  in_sh;
  logic [7:0]  byte_val;
  logic        byte_done;
  logic [7:0]  cmd;
  logic [31:0] wr_buf;
  logic [31:0] out_sh;
  logic [31:0] rd_word;
  logic [7:0]  boot_dcnt;
  logic [2:0]  boot_bit;
  logic        boot_shift;
  logic        boot_go;
  logic [7:0]  config_one;
  logic [7:0]  next_config_one;
  logic [2:0]  bp_level;
  logic [2:0]  next_bp_level;
  logic        wr_err;
  logic        prog_err;
  logic        wel;
  logic [31:0] boot_read_config;
  logic        boot_armed;
  logic        por_pending;
  logic        reset_load;
  logic        hard_reset;
  logic        wrr_commit;
  logic        boot_commit;
  logic        short_cmd;
  logic        soft_reset;
  logic [7:0]  status_one;
  logic [7:0]  status_two;
  logic [7:0]  otp_open;
  logic [7:0]  boot_delay;
  latency_if   lat ();

  // Two-stage sync of all pins, third stage for edges
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta <= PIN_SYNC_RST;
      pin_sync <= PIN_SYNC_RST;
      sck_d    <= 1'b0;
      cs_d     <= 1'b1;
    end else begin
      pin_meta <= {i_reset_b, i_hold_b, i_wp_b, i_si, i_cs_b, i_sck};
      pin_sync <= pin_meta;
      sck_d    <= pin_sync[0];
      cs_d     <= pin_sync[1];
    end
  end

  assign sck_s  = pin_sync[0];
  assign cs_s   = pin_sync[1];
  assign si_s   = pin_sync[2];
  assign wp_s   = pin_sync[3];
  assign hold_s = pin_sync[4];
  assign hw_low = ~pin_sync[5];

  // Pause pin only acts outside four-bit width
  assign link_run = ~cs_s & (config_one[CFG_QUAD] | hold_s);
  assign sck_rise = link_run & sck_s & ~sck_d;
  assign sck_fall = link_run & ~sck_s & sck_d;
  assign cs_rise  = cs_s & ~cs_d;
  assign cs_fall  = ~cs_s & cs_d;
  assign boot_go  = cs_fall & boot_armed & boot_read_config[BOOT_EN];

  // Serial input always on the single line
  assign byte_val  = {in_sh[6:0], si_s};
  assign byte_done = (bit_cnt == 3'h7);

  assign status_one = {1'b0, prog_err, 1'b0, bp_level, wel, 1'b0};
  assign status_two = {6'h00, i_erase_suspended, i_program_suspended};
  assign boot_delay = boot_read_config[BOOT_DLY_HI:BOOT_DLY_LO];

  // Command decode and read word selection
  always_comb begin
    next_st = ST_SKIP;
    rd_word = 32'h0000_0000;
    case (byte_val)
      CMD_WRITE_REGS, CMD_BOOT_REG_WRITE: next_st = ST_WRITE;
      CMD_READ_STATUS_ONE: begin
        next_st = ST_READ;
        rd_word = {4{status_one}};
      end
      CMD_READ_CONFIG_ONE: begin
        next_st = ST_READ;
        rd_word = {4{config_one}};
      end
      CMD_READ_STATUS_TWO: begin
        next_st = ST_READ;
        rd_word = {4{status_two}};
      end
      CMD_BOOT_REG_READ: begin
        next_st = ST_READ;
        rd_word = {boot_read_config[7:0], boot_read_config[15:8],
                   boot_read_config[23:16], boot_read_config[31:24]};
      end
      default: next_st = ST_SKIP;
    endcase
  end

  // Link state, bit and byte counting, write capture
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st       <= ST_IDLE;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      in_sh    <= 8'h00;
      cmd      <= 8'h00;
      wr_buf   <= 32'h0000_0000;
    end else if (hw_low || cs_s) begin
      st       <= ST_IDLE;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (cs_fall) begin
      st     <= boot_go ? ST_BOOT : ST_CMD;
      wr_buf <= 32'h0000_0000;
    end else if (sck_rise) begin
      in_sh   <= byte_val;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        unique case (st)
          ST_CMD: begin
            cmd <= byte_val;
            st  <= next_st;
          end
          ST_WRITE, ST_READ, ST_SKIP: begin
            if (byte_cnt != 3'h7) begin
              byte_cnt <= byte_cnt + 3'h1;
            end
            if (st == ST_WRITE && !byte_cnt[2]) begin
              wr_buf[{byte_cnt[1:0], 3'b000} +: 8] <= byte_val;
            end
          end
          ST_IDLE, ST_BOOT: begin
            cmd <= cmd;
          end
        endcase
      end
    end
  end

  // Boot output shifts once the start delay has elapsed
  assign boot_shift = (st == ST_BOOT) && sck_fall &&
                      ({1'b0, boot_dcnt} + 9'h001 >= {1'b0, boot_delay});

  // Serial output path for register reads and boot stream
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_so         <= 1'b0;
      o_so_oe_b    <= 1'b1;
      out_sh       <= 32'h0000_0000;
      boot_dcnt    <= 8'h00;
      boot_bit     <= 3'h0;
      o_array_addr <= 32'h0000_0000;
    end else if (hw_low || cs_s) begin
      o_so_oe_b    <= 1'b1;
      boot_dcnt    <= 8'h00;
      boot_bit     <= 3'h0;
      o_array_addr <= {boot_read_config[BOOT_ADDR_HI:BOOT_ADDR_LO],
                       9'h000};
    end else if (boot_go && boot_delay == 8'h00) begin
      // No delay: first bit goes out with the select edge
      o_so         <= i_array_byte[7];
      o_so_oe_b    <= 1'b0;
      out_sh[31:24] <= {i_array_byte[6:0], 1'b0};
      boot_bit     <= 3'h1;
    end else if (boot_shift) begin
      o_so_oe_b <= 1'b0;
      boot_dcnt <= boot_delay;
      boot_bit  <= boot_bit + 3'h1;
      if (boot_bit == 3'h0) begin
        o_so          <= i_array_byte[7];
        out_sh[31:24] <= {i_array_byte[6:0], 1'b0};
      end else begin
        o_so          <= out_sh[31];
        out_sh[31:24] <= {out_sh[30:24], 1'b0};
      end
      if (boot_bit == 3'h7) begin
        o_array_addr <= o_array_addr + 32'h0000_0001;
      end
    end else if ((st == ST_BOOT) && sck_fall) begin
      boot_dcnt <= boot_dcnt + 8'h01;
    end else if (sck_rise && byte_done && st == ST_CMD) begin
      out_sh <= rd_word;
    end else if (sck_fall && st == ST_READ) begin
      // Rotate so a long read repeats the register
      o_so      <= out_sh[31];
      o_so_oe_b <= 1'b0;
      out_sh    <= {out_sh[30:0], out_sh[31]};
    end
  end

  // Command execution at select release
  assign wrr_commit  = cs_rise && st == ST_WRITE && cmd == CMD_WRITE_REGS &&
                       wel && bit_cnt == 3'h0 && byte_cnt != 3'h0;
  assign boot_commit = cs_rise && st == ST_WRITE &&
                       cmd == CMD_BOOT_REG_WRITE && wel &&
                       bit_cnt == 3'h0 && byte_cnt >= 3'h4;
  assign short_cmd   = cs_rise && st == ST_SKIP && bit_cnt == 3'h0 &&
                       byte_cnt == 3'h0;
  assign soft_reset  = short_cmd && cmd == CMD_SOFT_RESET;
  assign hard_reset  = por_pending | hw_low;
  assign reset_load  = hard_reset | soft_reset;

  // Which one-time bits may still be raised
  assign otp_open = config_one[CFG_LOCK] ?
                    (CFG_OTP_MASK & ~CFG_FROZEN_MASK) :
                    CFG_OTP_MASK;

  // Register write merge with one-time and lock semantics
  always_comb begin
    next_config_one = config_one;
    next_bp_level   = bp_level;
    wr_err          = 1'b0;
    if (wrr_commit) begin
      if (!config_one[CFG_LOCK]) begin
        next_bp_level = wr_buf[STS_BP_HI:STS_BP_LO];
      end
      if (byte_cnt >= 3'h2) begin
        next_config_one[CFG_LC_HI:CFG_LC_LO] =
          wr_buf[8 + CFG_LC_HI -: 2];
        next_config_one[CFG_QUAD] = wr_buf[8 + CFG_QUAD];
        // Lock joins the same write; gating uses the old lock
        next_config_one[CFG_LOCK] = config_one[CFG_LOCK] |
                                    wr_buf[8 + CFG_LOCK];
        next_config_one = (next_config_one & ~otp_open) |
                          ((config_one | wr_buf[15:8]) & otp_open);
        wr_err = |(config_one & ~wr_buf[15:8] & otp_open);
      end
    end
  end

  // Power-on load pending until the first clock after release
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_pending <= 1'b1;
    end else begin
      por_pending <= 1'b0;
    end
  end

  // Configuration, protection level and error flag
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      config_one <= CONFIG_ONE_RST;
      bp_level   <= BP_LEVEL_RST;
      prog_err   <= 1'b0;
    end else begin
      config_one <= next_config_one;
      if (hard_reset) begin
        config_one[CFG_LOCK] <= 1'b0;
      end
      if (reset_load && config_one[CFG_BP_VOLATILE]) begin
        bp_level <= BP_VOLATILE_LOAD;
      end else begin
        bp_level <= next_bp_level;
      end
      // Set wins over the reset clear
      prog_err <= wr_err | (prog_err & ~reset_load);
    end
  end

  // Write enable latch, boot register and boot arming
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wel              <= 1'b0;
      boot_read_config <= BOOT_REG_RST;
      boot_armed       <= 1'b0;
    end else begin
      if (reset_load || (cs_rise && st == ST_WRITE)) begin
        wel <= 1'b0;
      end else if (short_cmd && cmd == CMD_WRITE_ENABLE) begin
        wel <= 1'b1;
      end
      if (boot_commit) begin
        boot_read_config <= wr_buf;
      end
      // Any reset arms; the next select edge disarms
      boot_armed <= reset_load | (boot_armed & ~cs_fall);
    end
  end

  assign lat.kind = i_ddr_read_kind;
  assign lat.code = config_one[CFG_LC_HI:CFG_LC_LO];

  ddr_latency_table u_latency (
    .lat (lat)
  );

  // Registered latency and pin-function outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ddr_mode_cycles  <= 3'h0;
      o_ddr_dummy_cycles <= 4'h0;
      o_wp_b_int         <= 1'b1;
      o_hold_b_int       <= 1'b1;
      o_data_line_two    <= 1'b0;
      o_data_line_three  <= 1'b0;
    end else begin
      o_ddr_mode_cycles  <= lat.mode;
      o_ddr_dummy_cycles <= lat.dummy;
      o_wp_b_int   <= config_one[CFG_QUAD] | wp_s;
      o_hold_b_int <= config_one[CFG_QUAD] | hold_s;
      o_data_line_two   <= config_one[CFG_QUAD] & wp_s;
      o_data_line_three <= config_one[CFG_QUAD] & hold_s;
    end
  end

  // Configuration views
  assign o_latency_code        = config_one[CFG_LC_HI:CFG_LC_LO];
  assign o_block_prot_level    = bp_level;
  assign o_protect_from_bottom = config_one[CFG_PROT_BOTTOM];
  assign o_param_sector_top    = config_one[CFG_PARAM_TOP] &
                                 ~i_uniform_sectors;
  assign o_protection_locked   = config_one[CFG_LOCK];
  assign o_program_error       = prog_err;
  assign o_quad_en             = config_one[CFG_QUAD];
  assign o_boot_active         = (st == ST_BOOT);

endmodule : flash_config_status_regs

//--- tb/flash_config_status_regs_assertions.sv
`timescale 1ns/1ns
module flash_config_status_regs_checker
  import flash_cfg_pkg::*;
(
  // Clock, reset and pins
  input wire logic           i_sys_clk,
  input wire logic           i_rst_b,
  input wire logic           i_cs_b,
  input wire logic           i_reset_b,
  input wire logic           i_uniform_sectors,
  input wire ddr_read_kind_t i_ddr_read_kind,
  // Observed outputs
  input wire logic           o_so_oe_b,
  input wire logic           o_boot_active,
  input wire logic [31:0]    o_array_addr,
  input wire logic [1:0]     o_latency_code,
  input wire logic [2:0]     o_ddr_mode_cycles,
  input wire logic [3:0]     o_ddr_dummy_cycles,
  input wire logic           o_protect_from_bottom,
  input wire logic           o_param_sector_top,
  input wire logic           o_protection_locked,
  input wire logic           o_quad_en,
  input wire logic           o_wp_b_int,
  input wire logic           o_hold_b_int,
  input wire logic           o_data_line_two,
  input wire logic           o_data_line_three
);
  // One domain; power-on reset disables every check
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Latency lookups
  a_mode_dual: assert property (
    i_ddr_read_kind == DDR_DUAL_READ |=> o_ddr_mode_cycles == 3'h2)
    else $error("dual read mode cycles off");
  a_dummy_quad: assert property (
    i_ddr_read_kind == DDR_QUAD_READ && o_latency_code == 2'b10
    |=> o_ddr_dummy_cycles == 4'h8)
    else $error("quad read dummy cycles off");
  // Protection origin bit never drops; parameter location off in uniform layout
  a_otp_sticky: assert property (
    o_protect_from_bottom |=> o_protect_from_bottom)
    else $error("protection origin returned to zero");
  a_param_uniform: assert property (
    i_uniform_sectors |-> !o_param_sector_top)
    else $error("parameter location active in uniform layout");
  // Lock behaviour
  a_lock_frozen: assert property (
    o_protection_locked && $past(o_protection_locked)
    |-> $stable(o_protect_from_bottom))
    else $error("origin changed while locked");
  a_lock_hold: assert property (
    i_reset_b [*5] ##0 o_protection_locked |=> o_protection_locked)
    else $error("lock cleared without reset pin");
  // Four-bit width pin use
  a_quad_pins: assert property (
    o_quad_en && $past(o_quad_en) |-> o_wp_b_int && o_hold_b_int)
    else $error("pin functions not held inactive");
  a_lines_zero: assert property (
    !o_quad_en && !$past(o_quad_en)
    |-> !o_data_line_two && !o_data_line_three)
    else $error("data lines active without four-bit width");
  // Boot address alignment and idle output
  a_boot_align: assert property (
    i_cs_b [*4] |-> o_array_addr[8:0] == 9'h000)
    else $error("boot address not block aligned");
  a_oe_idle: assert property (
    i_cs_b [*6] |-> o_so_oe_b)
    else $error("output driven while deselected");
  a_boot_idle: assert property (
    i_cs_b [*4] |-> !o_boot_active)
    else $error("boot stream active while deselected");
endmodule : flash_config_status_regs_checker

bind flash_config_status_regs flash_config_status_regs_checker i_chk (.*);

//--- tb/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
  // Pacing clock
  input  wire logic i_sys_clk,
  // Link pins
  output logic      o_sck,
  output logic      o_cs_b,
  output logic      o_si,
  input  wire logic i_so,
  // Received bytes
  output logic [7:0] o_rd_byte,
  output logic       o_rd_stb
);
  // Idle link: clock low, deselected
  initial begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_si = 1'b0;
    o_rd_byte = 8'h00;
    o_rd_stb = 1'b0;
  end

  // Wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #2;
  endtask : tick

  // Mode-0 frame, MSB first; bytes from index first are reported
  // Only register and single-line commands are sent
  task automatic xfer(input logic [63:0] tx, input int n, input int first);
    logic [7:0] rx;
    tick(1);
    o_cs_b = 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        o_si = tx[56 - 8 * b + i];
        tick(4);
        o_sck = 1'b1;
        rx[i] = i_so;
        tick(4);
        o_sck = 1'b0;
      end
      o_rd_byte = rx;
      o_rd_stb = (b >= first);
      tick(1);
      o_rd_stb = 1'b0;
    end
    tick(4);
    o_cs_b = 1'b1;
    tick(8);
  endtask : xfer
endmodule : spi_host_model

//--- tb/flash_config_status_regs_tb.sv
`timescale 1ns/1ns
module flash_config_status_regs_tb;
  import flash_cfg_pkg::*;
  logic i_sys_clk, i_rst_b, i_sck, i_cs_b, i_si, i_wp_b, i_hold_b;
  logic i_reset_b, o_so, o_so_oe_b, i_erase_suspended, rd_stb;
  logic i_program_suspended, i_uniform_sectors, o_boot_active;
  ddr_read_kind_t i_ddr_read_kind;
  logic [7:0]  i_array_byte, rd_byte;
  logic [31:0] o_array_addr, r;
  logic [1:0]  o_latency_code;
  logic [2:0]  o_ddr_mode_cycles, o_block_prot_level;
  logic [3:0]  o_ddr_dummy_cycles;
  logic o_protect_from_bottom, o_param_sector_top, o_protection_locked;
  logic o_program_error, o_quad_en, o_wp_b_int, o_hold_b_int;
  logic o_data_line_two, o_data_line_three;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 32'h522e;
  logic [7:0] expq [$];
  logic [7:0] mode_x [3] = '{8'h04, 8'h02, 8'h01};
  logic [7:0] dum [3][4] = '{'{8'h02, 8'h04, 8'h05, 8'h01},
                            '{8'h04, 8'h05, 8'h06, 8'h02},
                            '{8'h06, 8'h07, 8'h08, 8'h03}};

  flash_config_status_regs i_dut (.*);
  spi_host_model i_host (.i_sys_clk(i_sys_clk), .o_sck(i_sck),
    .o_cs_b(i_cs_b), .o_si(i_si), .i_so(o_so), .o_rd_byte(rd_byte),
    .o_rd_stb(rd_stb));

  // Clock and array contents
  initial i_sys_clk = 1'b0;
  always #20 i_sys_clk = ~i_sys_clk;
  assign i_array_byte = o_array_addr[7:0] ^ 8'hA5;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // Read bytes arrive: compare against the oldest note
  always @(posedge i_sys_clk) begin
    if (rd_stb === 1'b1) begin
      cmp(rd_byte, expq.size() > 0 ? expq.pop_front() : 8'hxx);
    end
  end

  task automatic rd(input logic [7:0] c, input logic [31:0] e, input int n);
    for (int k = 0; k < n; k++) expq.push_back(e[8 * k +: 8]);
    i_host.xfer({c, 56'h0}, n + 1, 1);
  endtask : rd

  task automatic wr(input logic [63:0] f, input int n);
    i_host.xfer({CMD_WRITE_ENABLE, 56'h0}, 1, 1);
    i_host.xfer(f, n, n);
  endtask : wr

  task automatic pin_reset();
    i_reset_b = 1'b0;
    i_host.tick(4);
    i_reset_b = 1'b1;
    i_host.tick(4);
  endtask : pin_reset

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog
  initial begin
    #3_000_000;
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial begin
    i_rst_b = 1'b0;
    i_reset_b = 1'b1;
    i_wp_b = 1'b1;
    i_hold_b = 1'b1;
    {i_erase_suspended, i_program_suspended} = 2'b00;
    i_uniform_sectors = 1'b0;
    i_ddr_read_kind = DDR_FAST_READ;
    i_host.tick(10);
    i_rst_b = 1'b1;
    i_host.tick(4);
    rd(CMD_READ_CONFIG_ONE, 32'h0000_0000, 1);
    rd(CMD_BOOT_REG_READ, 32'h0000_0000, 4);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      i_erase_suspended = r[1];
      i_program_suspended = r[0];
      rd(CMD_READ_STATUS_TWO, {30'h0, r[1:0]}, 1);
    end
    $display("reset values and suspend flags done");
    for (int c = 0; c < 4; c++) begin
      wr({CMD_WRITE_REGS, 8'h00, 2'(c), 6'h00, 40'h0}, 3);
      cmp({6'h00, o_latency_code}, 8'(c));
      for (int k = 0; k < 3; k++) begin
        i_ddr_read_kind = ddr_read_kind_t'(k);
        i_host.tick(2);
        cmp({5'h00, o_ddr_mode_cycles}, mode_x[k]);
        cmp({4'h0, o_ddr_dummy_cycles}, dum[k][c]);
      end
    end
    $display("latency table done");
    wr({CMD_WRITE_REGS, 8'h0C, 8'h2E, 40'h0}, 3);
    // Random pin levels; four-bit width stays on from here
    r = $random(seed);
    i_wp_b = r[2];
    i_hold_b = r[3];
    i_uniform_sectors = r[4];
    i_host.tick(4);
    cmp({3'h0, o_quad_en, o_wp_b_int, o_hold_b_int, o_data_line_two,
         o_data_line_three}, {6'h07, r[2], r[3]});
    cmp({o_protect_from_bottom, o_param_sector_top},
        {7'h01, ~r[4]});
    i_uniform_sectors = ~r[4];
    i_host.tick(2);
    cmp({o_protect_from_bottom, o_param_sector_top},
        {7'h01, r[4]});
    rd(CMD_READ_STATUS_ONE, 32'h0000_000C, 1);
    wr({CMD_WRITE_REGS, 8'h0C, 8'h02, 40'h0}, 3);
    rd(CMD_READ_CONFIG_ONE, 32'h0000_002E, 1);
    rd(CMD_READ_STATUS_ONE, 32'h0000_004C, 1);
    cmp({7'h00, o_program_error}, 8'h01);
    pin_reset();
    rd(CMD_READ_STATUS_ONE, 32'h0000_001C, 1);
    rd(CMD_READ_CONFIG_ONE, 32'h0000_002E, 1);
    $display("one-time bits and four-bit width done");
    wr({CMD_WRITE_REGS, 8'h1C, 8'hEF, 40'h0}, 3);
    rd(CMD_READ_CONFIG_ONE, 32'h0000_00EF, 1);
    wr({CMD_WRITE_REGS, 8'h00, 8'hEF, 40'h0}, 3);
    cmp({5'h00, o_block_prot_level}, 8'h07);
    i_host.xfer({CMD_SOFT_RESET, 56'h0}, 1, 1);
    cmp({7'h00, o_protection_locked}, 8'h01);
    pin_reset();
    cmp({7'h00, o_protection_locked}, 8'h00);
    $display("lock done");
    wr({CMD_BOOT_REG_WRITE, 32'h0102_0000, 24'h0}, 5);
    rd(CMD_BOOT_REG_READ, 32'h0000_0201, 4);
    i_host.xfer({CMD_SOFT_RESET, 56'h0}, 1, 1);
    cmp(o_array_addr[15:8], 8'h02);
    expq.push_back(8'hA5);
    expq.push_back(8'hA4);
    i_host.xfer(64'h0, 2, 0);
    $display("boot read done");
    end_sim();
  end
endmodule : flash_config_status_regs_tb
